// *** logic/atfc_device.sv ***
// atfc_device: command engine end; checks request frames, keeps settings,
// builds response frames. assumes host traffic on the link interface.
// Operation
// - local requests answered with type 0x88
// - zero tag suppresses the local response
// - discovery command yields two response frames
// - delimiter then 16-bit length of body
// - checksum is 0xff minus body sum
// - response echoes request tag at offset 4
// - command name at offset 5, both directions
// - status byte at offset 7, codes 0-3
// - set requests answered without data bytes
// - queries answered with the current value
// - type 0x17 is a remote command request
// - remote tag at 4, zero means silent
// - host puts 64-bit destination at 5
// - host puts 16-bit destination at 13
// - option bits: no ack, apply, secure
// - host zeroes reserved option bits
// - unapplied writes held until apply; one pend slot only, a later queued write replaces the pending one
// - remote command at 16, param from 18
// - secure only after session established; no session is tracked, opt_secure_req follows the bit as sent
// - remote answer is type 0x97 with tag
// - host sends remote requests unicast only; the host sends any destination as software wrote it, unchecked
`timescale 1ns/1ps
module atfc_device
  import atfc_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // link to host
  atfc_link_if.dev         link,
  // settings updates to the radio side
  output logic             set_strobe,
  output logic [2:0]       set_index,
  output logic [15:0]      set_value,
  // request options and errors
  output logic             opt_secure_req,
  output logic             opt_no_ack_req,
  output logic             bad_frame
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_HUNT  = 3'b000, // wait for delimiter
    ST_LENH  = 3'b001,
    ST_LENL  = 3'b010,
    ST_BODY  = 3'b011,
    ST_SUM   = 3'b100, // checksum byte
    ST_SEND  = 3'b101  // response out, input stalled
  } atfc_dev_st_e;

  typedef struct packed {
    atfc_dev_st_e     st;
    logic [15:0]      len;      // body length from header
    logic [15:0]      idx;      // byte offset of next input byte
    logic [7:0]       sum;      // running body sum
    logic [7:0]       typ;
    logic [7:0]       tag;
    logic [15:0]      cmd;
    logic [7:0]       opts;
    logic [15:0]      pcnt;     // parameter bytes seen
    logic [15:0]      pval;     // last two parameter bytes
    logic [7:0][15:0] vals;     // live settings
    logic             pend;     // a queued write waits
    logic [2:0]       pidx;
    logic [15:0]      pv;
    logic [7:0]       rtyp;     // response type
    logic [7:0]       rstat;
    logic             rquery;   // response carries data
    logic [15:0]      rlen;
    logic [1:0]       rleft;    // extra frames still owed
    logic [15:0]      tidx;
    logic [7:0]       tsum;
    logic             txv;
    logic [7:0]       txd;
    logic             rdy;
    logic             sstb;
    logic [2:0]       sidx;
    logic [15:0]      sval;
    logic             sec;
    logic             noack;
    logic             bad;
  } atfc_dev_s;

  atfc_dev_s s;      // registered state
  atfc_dev_s next_s; // next state

  logic fire_in;  // byte taken from host
  logic fire_out; // byte taken by host
  assign fire_in  = link.h2d_valid & s.rdy;
  assign fire_out = s.txv & link.d2h_ready;

  // ----------------------------------------------------------------------
  // response byte at a given offset
  // ----------------------------------------------------------------------
  function automatic logic [7:0] rsp_byte(input atfc_dev_s c);
    logic [15:0] v;
    v = c.vals[c.cmd[2:0]];
    rsp_byte = 8'h00;
    case (c.tidx)
      16'h0000:   rsp_byte = frame_delim;
      ofs_len_hi: rsp_byte = c.rlen[15:8];
      ofs_len_lo: rsp_byte = c.rlen[7:0];
      ofs_type:   rsp_byte = c.rtyp;
      ofs_tag:    rsp_byte = c.tag;
      ofs_lcmd:   rsp_byte = c.cmd[15:8];
      16'h0006:   rsp_byte = c.cmd[7:0];
      ofs_status: rsp_byte = c.rstat;
      ofs_ldata:  rsp_byte = v[15:8];
      16'h0009:   rsp_byte = v[7:0];
      default:    rsp_byte = 8'h00;
    endcase
    if (c.tidx == c.rlen + 16'h0003) begin
      rsp_byte = sum_base - c.tsum;
    end
  endfunction : rsp_byte

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic        remote;
    logic        local_req;
    logic [15:0] cofs;
    logic [15:0] pofs;
    logic [2:0]  ci;
    logic        wr;
    logic        now;
    next_s   = s;
    remote   = (s.typ == type_rem_req);
    local_req = (s.typ == type_loc_req) | (s.typ == type_loc_qreq);
    cofs     = remote ? ofs_rcmd : ofs_lcmd;
    pofs     = remote ? ofs_rparam : ofs_lparam;
    ci       = s.cmd[2:0];
    wr       = 1'b0;
    now      = 1'b0;
    next_s.sstb = 1'b0;
    next_s.bad  = 1'b0;
    case (s.st)
      ST_HUNT: begin
        if (fire_in && link.h2d_data == frame_delim) begin
          next_s.st = ST_LENH;
        end
      end
      ST_LENH: begin
        if (fire_in) begin
          next_s.len[15:8] = link.h2d_data;
          next_s.st = ST_LENL;
        end
      end
      ST_LENL: begin
        if (fire_in) begin
          next_s.len[7:0] = link.h2d_data;
          next_s.idx  = ofs_type;
          next_s.sum  = 8'h00;
          next_s.typ  = 8'h00;
          next_s.tag  = 8'h00;
          next_s.opts = 8'h00;
          next_s.pcnt = 16'h0000;
          next_s.pval = 16'h0000;
          // empty body goes straight to checksum
          next_s.st = ({s.len[15:8], link.h2d_data} == 16'h0000) ?
                      ST_SUM : ST_BODY;
        end
      end
      ST_BODY: begin
        if (fire_in) begin
          next_s.sum = s.sum + link.h2d_data;
          if (s.idx == ofs_type) next_s.typ = link.h2d_data;
          if (s.idx == ofs_tag) next_s.tag = link.h2d_data;
          if (s.idx == cofs) next_s.cmd[15:8] = link.h2d_data;
          if (s.idx == cofs + 16'h0001) begin
            next_s.cmd[7:0] = link.h2d_data;
          end
          if (remote && s.idx == ofs_opts) begin
            next_s.opts = link.h2d_data;
          end
          if (s.idx >= pofs && s.idx > ofs_tag) begin
            next_s.pcnt = s.pcnt + 16'h0001;
            next_s.pval = {s.pval[7:0], link.h2d_data};
          end
          next_s.idx = s.idx + 16'h0001;
          if (s.idx == s.len + 16'h0002) next_s.st = ST_SUM;
        end
      end
      ST_SUM: begin
        if (fire_in) begin
          next_s.st = ST_HUNT;
          if (s.sum + link.h2d_data != sum_base) begin
            next_s.bad = 1'b1;
          end else if (local_req || remote) begin
            // parameter wider than a stored value is refused
            next_s.rstat = (s.pcnt > val_bytes) ? st_bad_param : st_ok;
            wr  = (s.pcnt != 16'h0000) && (s.pcnt <= val_bytes);
            now = (s.typ == type_loc_req) ||
                  (remote && s.opts[opt_apply]);
            if (remote) begin
              next_s.sec   = s.opts[opt_secure];
              next_s.noack = s.opts[opt_no_ack];
            end
            // pending write goes live on apply command or any applying request
            if (s.pend && (now || s.cmd == apply_changes_cmd)) begin
              next_s.vals[s.pidx] = s.pv;
              next_s.pend = 1'b0;
              next_s.sstb = 1'b1;
              next_s.sidx = s.pidx;
              next_s.sval = s.pv;
            end
            if (wr && now) begin
              next_s.vals[ci] = s.pval;
              next_s.sstb = 1'b1;
              next_s.sidx = ci;
              next_s.sval = s.pval;
            end else if (wr) begin
              next_s.pend = 1'b1;
              next_s.pidx = ci;
              next_s.pv   = s.pval;
            end
            next_s.rquery = (s.pcnt == 16'h0000);
            next_s.rlen   = (s.pcnt == 16'h0000) ?
                            rsp_len + val_bytes : rsp_len;
            next_s.rtyp   = remote ? type_rem_rsp : type_loc_rsp;
            next_s.rleft  = (s.cmd == network_discovery_cmd) ?
                            discover_frames - 2'h1 : 2'h0;
            next_s.tidx   = 16'h0000;
            next_s.tsum   = 8'h00;
            if (s.tag != 8'h00) next_s.st = ST_SEND;
          end
        end
      end
      ST_SEND: begin
        if (!s.txv || fire_out) begin
          if (s.tidx > s.rlen + 16'h0003) begin
            next_s.txv = 1'b0;
            if (s.rleft != 2'h0) begin
              next_s.rleft = s.rleft - 2'h1;
              next_s.tidx  = 16'h0000;
              next_s.tsum  = 8'h00;
            end else begin
              next_s.st = ST_HUNT;
            end
          end else begin
            next_s.txv  = 1'b1;
            next_s.txd  = rsp_byte(s);
            next_s.tidx = s.tidx + 16'h0001;
            if (s.tidx >= ofs_type) begin
              next_s.tsum = s.tsum + rsp_byte(s);
            end
          end
        end
      end
      default: next_s.st = ST_HUNT;
    endcase
    // input stalls while a response is going out
    next_s.rdy = (next_s.st != ST_SEND);
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state flops
  assign link.h2d_ready = s.rdy;
  assign link.d2h_valid = s.txv;
  assign link.d2h_data  = s.txd;
  assign set_strobe     = s.sstb;
  assign set_index      = s.sidx;
  assign set_value      = s.sval;
  assign opt_secure_req = s.sec;
  assign opt_no_ack_req = s.noack;
  assign bad_frame      = s.bad;
endmodule : atfc_device

// *** logic/atfc_pkg.sv ***
// atfc_pkg: frame constants shared by both ends of the command codec
// assumes one 10 MHz clock and byte-wide streams between the two ends
package atfc_pkg;
  // --------------------------------------------------------------------
  // frame bytes and types
  // --------------------------------------------------------------------
  localparam logic [7:0]  frame_delim   = 8'h7e; // start of every frame
  localparam logic [7:0]  sum_base      = 8'hff; // checksum is this - sum
  localparam logic [7:0]  type_loc_req  = 8'h08; // local request, apply
  localparam logic [7:0]  type_loc_qreq = 8'h09; // local request, queued
  localparam logic [7:0]  type_loc_rsp  = 8'h88; // local response
  localparam logic [7:0]  type_rem_req  = 8'h17; // remote request
  localparam logic [7:0]  type_rem_rsp  = 8'h97; // remote response
  // --------------------------------------------------------------------
  // byte offsets within a frame
  // --------------------------------------------------------------------
  localparam logic [15:0] ofs_len_hi    = 16'h0001;
  localparam logic [15:0] ofs_len_lo    = 16'h0002;
  localparam logic [15:0] ofs_type      = 16'h0003; // first summed byte
  localparam logic [15:0] ofs_tag       = 16'h0004;
  localparam logic [15:0] ofs_lcmd      = 16'h0005; // local command name
  localparam logic [15:0] ofs_status    = 16'h0007;
  localparam logic [15:0] ofs_lparam    = 16'h0007; // local param 7/data 8
  localparam logic [15:0] ofs_ldata     = 16'h0008;
  localparam logic [15:0] ofs_dest64    = 16'h0005;
  localparam logic [15:0] ofs_dest16    = 16'h000d;
  localparam logic [15:0] ofs_opts      = 16'h000f;
  localparam logic [15:0] ofs_rcmd      = 16'h0010;
  localparam logic [15:0] ofs_rparam    = 16'h0012;
  localparam logic [15:0] loc_req_len   = 16'h0004; // type,tag,cmd
  localparam logic [15:0] rem_req_len   = 16'h000f; // up to options+cmd
  localparam logic [15:0] rsp_len       = 16'h0005; // type,tag,cmd,status
  localparam logic [15:0] val_bytes     = 16'h0002; // stored value width
  // --------------------------------------------------------------------
  // status codes, option bits, commands
  // --------------------------------------------------------------------
  localparam logic [7:0]  st_ok         = 8'h00;
  localparam logic [7:0]  st_error      = 8'h01;
  localparam logic [7:0]  st_bad_cmd    = 8'h02;
  localparam logic [7:0]  st_bad_param  = 8'h03;
  localparam int          opt_no_ack    = 0;     // bit 0
  localparam int          opt_apply     = 1;     // bit 1
  localparam int          opt_secure    = 4;     // bit 4
  localparam logic [7:0]  opt_used_mask = 8'h13; // reserved bits stay 0
  localparam logic [15:0] apply_changes_cmd     = 16'h4143;
  localparam logic [15:0] network_discovery_cmd = 16'h4e44;
  localparam logic [1:0]  discover_frames       = 2'h2; // replies per scan
  // --------------------------------------------------------------------
  // host register map (apb byte addresses)
  // --------------------------------------------------------------------
  localparam logic [7:0]  reg_ctrl      = 8'h00; // bit0 send
  localparam logic [7:0]  reg_req       = 8'h04; // type,tag,cmd
  localparam logic [7:0]  reg_dst_hi    = 8'h08;
  localparam logic [7:0]  reg_dst_lo    = 8'h0c;
  localparam logic [7:0]  reg_dst_opt   = 8'h10; // dest16,opts,plen
  localparam logic [7:0]  reg_param     = 8'h14;
  localparam logic [7:0]  reg_stat      = 8'h18;
  localparam logic [7:0]  reg_rdata     = 8'h1c;
endpackage : atfc_pkg

// *** logic/atfc_link_if.sv ***
// atfc_link_if: byte streams between host and device, one each way
// assumes both ends share pclk; valid/ready handshake on every byte
`timescale 1ns/1ps
interface atfc_link_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic [7:0] h2d_data;  // host to device byte
  logic       h2d_valid;
  logic       h2d_ready;
  logic [7:0] d2h_data;  // device to host byte
  logic       d2h_valid;
  logic       d2h_ready;
  modport dev (input h2d_data, h2d_valid, d2h_ready,
               output h2d_ready, d2h_data, d2h_valid);
  modport host (output h2d_data, h2d_valid, d2h_ready,
                input h2d_ready, d2h_data, d2h_valid);
endinterface : atfc_link_if

// *** logic/atfc_host.sv ***
// atfc_host: host end; software fills apb registers, hardware frames the
// request and parses the response. assumes the device on the link.
`timescale 1ns/1ps
module atfc_host
  import atfc_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // link to device
  atfc_link_if.host        link
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    HR_HUNT = 3'b000,
    HR_LENH = 3'b001,
    HR_LENL = 3'b010,
    HR_BODY = 3'b011,
    HR_SUM  = 3'b100
  } atfc_hrx_st_e;

  typedef struct packed {
    logic [31:0]  req;    // type,tag,cmd
    logic [63:0]  d64;
    logic [31:0]  dopt;   // dest16, opts, plen
    logic [15:0]  pv;
    logic         busy;
    logic [15:0]  tidx;
    logic [15:0]  tlen;
    logic [7:0]   tsum;
    logic         txv;
    logic [7:0]   txd;
    atfc_hrx_st_e rst;
    logic [15:0]  rlen;
    logic [15:0]  ridx;
    logic [7:0]   rsum;
    logic [23:0]  rhdr;   // type,tag,status
    logic [15:0]  rdat;
    logic         rvalid; // sticky, write 1 clears
    logic         rerr;   // sticky, write 1 clears
    logic         pready;
    logic [31:0]  prdata;
  } atfc_host_s;

  atfc_host_s s;
  atfc_host_s next_s;

  logic remote;
  logic wr_acc;
  assign remote = (s.req[31:24] == type_rem_req);
  assign wr_acc = psel & penable & s.pready & pwrite;

  // ----------------------------------------------------------------------
  // request byte at the current offset
  // ----------------------------------------------------------------------
  function automatic logic [7:0] req_byte(input atfc_host_s c,
                                          input logic rem);
    logic [15:0] po;
    logic [15:0] i;
    po = rem ? ofs_rparam : ofs_lparam;
    i  = c.tidx;
    req_byte = 8'h00;
    if (i == 16'h0000) req_byte = frame_delim;
    else if (i == ofs_len_hi) req_byte = c.tlen[15:8];
    else if (i == ofs_len_lo) req_byte = c.tlen[7:0];
    else if (i == ofs_type) req_byte = c.req[31:24];
    else if (i == ofs_tag) req_byte = c.req[23:16];
    else if (i == c.tlen + 16'h0003) req_byte = sum_base - c.tsum;
    else if (i == po) req_byte = (c.dopt[1:0] == 2'h2) ?
                                 c.pv[15:8] : c.pv[7:0];
    else if (i == po + 16'h0001) req_byte = c.pv[7:0];
    else if (rem && i < ofs_dest16)
      req_byte = c.d64[8'(16'h003f - ((i - ofs_dest64) << 3)) -: 8];
    else if (rem && i == ofs_dest16) req_byte = c.dopt[31:24];
    else if (rem && i == ofs_dest16 + 16'h0001) req_byte = c.dopt[23:16];
    else if (rem && i == ofs_opts)
      // secure bit goes out as software set it; no session is checked
      req_byte = c.dopt[15:8] & opt_used_mask;
    else if (i == (rem ? ofs_rcmd : ofs_lcmd))
      req_byte = c.req[15:8];
    else req_byte = c.req[7:0];
  endfunction : req_byte

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [7:0] b;
    next_s = s;
    b = req_byte(s, remote);
    // apb: one wait-free access, data prepared in setup
    next_s.pready = psel & ~penable;
    next_s.prdata = 32'h0000_0000;
    case (paddr)
      reg_req:     next_s.prdata = s.req;
      reg_dst_hi:  next_s.prdata = s.d64[63:32];
      reg_dst_lo:  next_s.prdata = s.d64[31:0];
      reg_dst_opt: next_s.prdata = s.dopt;
      reg_param:   next_s.prdata = {16'h0000, s.pv};
      reg_stat:    next_s.prdata = {s.rhdr, 5'h00, s.rerr, s.rvalid,
                                    s.busy};
      reg_rdata:   next_s.prdata = {16'h0000, s.rdat};
      default:     next_s.prdata = 32'h0000_0000;
    endcase
    if (wr_acc && !s.busy) begin
      case (paddr)
        reg_req:     next_s.req = pwdata;
        reg_dst_hi:  next_s.d64[63:32] = pwdata;
        reg_dst_lo:  next_s.d64[31:0] = pwdata;
        reg_dst_opt: next_s.dopt = pwdata;
        reg_param:   next_s.pv = pwdata[15:0];
        reg_ctrl: begin
          if (pwdata[0]) begin
            next_s.busy = 1'b1;
            next_s.tidx = 16'h0000;
            next_s.tsum = 8'h00;
            next_s.tlen = (remote ? rem_req_len : loc_req_len) +
                          {14'h0000, s.dopt[1:0]};
          end
        end
        default: next_s.busy = s.busy;
      endcase
    end
    if (wr_acc && paddr == reg_stat) begin
      if (pwdata[1]) next_s.rvalid = 1'b0;
      if (pwdata[2]) next_s.rerr = 1'b0;
    end
    // transmit
    if (s.busy && (!s.txv || (s.txv && link.h2d_ready))) begin
      if (s.tidx > s.tlen + 16'h0003) begin
        next_s.txv  = 1'b0;
        next_s.busy = 1'b0;
      end else begin
        next_s.txv  = 1'b1;
        next_s.txd  = b;
        next_s.tidx = s.tidx + 16'h0001;
        if (s.tidx >= ofs_type) next_s.tsum = s.tsum + b;
      end
    end
    // receive, always ready
    if (link.d2h_valid) begin
      case (s.rst)
        HR_HUNT: if (link.d2h_data == frame_delim) next_s.rst = HR_LENH;
        HR_LENH: begin
          next_s.rlen[15:8] = link.d2h_data;
          next_s.rst = HR_LENL;
        end
        HR_LENL: begin
          next_s.rlen[7:0] = link.d2h_data;
          next_s.ridx = ofs_type;
          next_s.rsum = 8'h00;
          next_s.rdat = 16'h0000;
          next_s.rst  = HR_BODY;
        end
        HR_BODY: begin
          next_s.rsum = s.rsum + link.d2h_data;
          if (s.ridx == ofs_type) next_s.rhdr[23:16] = link.d2h_data;
          if (s.ridx == ofs_tag) next_s.rhdr[15:8] = link.d2h_data;
          if (s.ridx == ofs_status) next_s.rhdr[7:0] = link.d2h_data;
          if (s.ridx > ofs_status) begin
            next_s.rdat = {s.rdat[7:0], link.d2h_data};
          end
          next_s.ridx = s.ridx + 16'h0001;
          if (s.ridx == s.rlen + 16'h0002) next_s.rst = HR_SUM;
        end
        HR_SUM: begin
          next_s.rst = HR_HUNT;
          // set wins over a clear in the same cycle
          if (s.rsum + link.d2h_data == sum_base) next_s.rvalid = 1'b1;
          else next_s.rerr = 1'b1;
        end
        default: next_s.rst = HR_HUNT;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pready          = s.pready;
  assign prdata          = s.prdata;
  assign pslverr         = 1'b0;
  assign link.h2d_valid  = s.txv;
  assign link.h2d_data   = s.txd;
  assign link.d2h_ready  = 1'b1;
endmodule : atfc_host

// *** verification/atfc_props.sv ***
// atfc_props: frame checks on the byte link between host and device
// assumes one pclk domain and async active-low presetn
`timescale 1ns/1ps
module atfc_props
  import atfc_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_valid,
  input wire logic       h2d_ready,
  input wire logic [7:0] d2h_data,
  input wire logic       d2h_valid,
  input wire logic       d2h_ready
);
  // trackers: index 0 request stream, 1 response stream
  logic [1:0][15:0] pos, len;  // byte offset, length field
  logic [1:0][7:0]  sm, dat;   // body sum, byte on wire
  logic [1:0]       hs, lst;   // byte taken, checksum byte
  logic [7:0]       tag, typ;  // tag and type of last request
  logic [7:0]       exp_ty;    // type the answer must carry
  assign dat = {d2h_data, h2d_data};
  assign hs = {d2h_valid & d2h_ready, h2d_valid & h2d_ready};
  assign lst[0] = pos[0] == len[0] + 16'h3;
  assign lst[1] = pos[1] == len[1] + 16'h3;
  assign exp_ty = typ == type_rem_req ? type_rem_rsp : type_loc_rsp;
  // sum restarts before offset 3 so stale frames never leak in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pos, len, sm, tag, typ} <= 96'h0;
    end else begin
      for (int i = 0; i < 2; i++)
        if (hs[i]) begin
          pos[i] <= lst[i] ? 16'h0 : pos[i] + 16'h1;
          if (pos[i] == ofs_len_hi) len[i][15:8] <= dat[i];
          if (pos[i] == ofs_len_lo) len[i][7:0] <= dat[i];
          sm[i] <= pos[i] < ofs_type ? 8'h0 : sm[i] + dat[i];
        end
      if (hs[0] && pos[0] == ofs_type) typ <= h2d_data;
      if (hs[0] && pos[0] == ofs_tag) tag <= h2d_data;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_stall; h2d_valid && !h2d_ready; endsequence
  sequence s_keep; h2d_valid && $stable(h2d_data); endsequence
  sequence s_req_end; hs[0] && lst[0] && |tag; endsequence
  property p_sum(i); hs[i] && lst[i] |-> dat[i] == sum_base - sm[i];
  endproperty
  property p_at(k, ok); hs[1] && pos[1] == k |-> ok; endproperty
  a_req_hold: assert property (s_stall |=> s_keep)
    else $error("request byte changed while stalled");
  a_req_sum: assert property (p_sum(0))
    else $error("request checksum wrong");
  a_rsp_sum: assert property (p_sum(1))
    else $error("response checksum wrong");
  a_rsp_delim: assert property (p_at(16'h0, d2h_data == frame_delim))
    else $error("response delimiter wrong");
  a_rsp_type: assert property (p_at(ofs_type, d2h_data == exp_ty))
    else $error("response type wrong");
  a_rsp_tag: assert property (p_at(ofs_tag, d2h_data == tag && |tag))
    else $error("response tag wrong");
  a_rsp_len: assert property (p_at(16'h2, d2h_data inside {5, 7}))
    else $error("response length wrong");
  a_rsp_start: assert property (s_req_end |-> ##[1:3] d2h_valid)
    else $error("response missing");
endmodule : atfc_props

// *** verification/at_command_frame_codec_tb.sv ***
// at_command_frame_codec_tb: apb-driven host framing requests to device
// assumes the logic/ files compile first
`timescale 1ns/1ps
module at_command_frame_codec_tb;
  import atfc_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, pready, pslverr;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  int          errors = 0, total_checks = 0;
  logic        stb, bad, sec, nak; // device side outputs
  logic [2:0]  sidx;
  logic [15:0] sval;
  int          strobes = 0, bads = 0; // settings gone live, dropped frames
  // rows: request, dest16/opts/plen, param, value a query must return
  logic [31:0] rows [7][4] = '{'{32'h08215450, 32'h2, 32'h1234, 32'h0},
    '{32'h09225450, 32'h2, 32'h00aa, 32'h0},
    '{32'h09235450, 32'h0, 32'h0, 32'h1234},
    '{32'h08244143, 32'h0, 32'h0, 32'h0},
    '{32'h08255450, 32'h0, 32'h0, 32'h00aa},
    '{32'h17264944, 32'hfffe0202, 32'h0451, 32'h0},
    '{32'h17274944, 32'hfffe1100, 32'h0, 32'h0451}};
  always #50 pclk = ~pclk;
  atfc_link_if link (.pclk, .presetn);
  atfc_host atfc_host_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .link);
  atfc_device atfc_device_i (.pclk, .presetn, .link, .set_strobe(stb),
    .set_index(sidx), .set_value(sval), .opt_secure_req(sec),
    .opt_no_ack_req(nak), .bad_frame(bad));
  // count one-cycle pulses as they stand at the edge
  always @(posedge pclk) begin
    if (stb === 1'b1) strobes++;
    if (bad === 1'b1) bads++;
  end
  atfc_props atfc_props_i (.pclk, .presetn, .h2d_data(link.h2d_data),
    .h2d_valid(link.h2d_valid), .h2d_ready(link.h2d_ready),
    .d2h_data(link.d2h_data), .d2h_valid(link.d2h_valid),
    .d2h_ready(link.d2h_ready));
  // one apb transfer; read data lands in rd
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    {psel, penable} <= 2'b0;
  endtask : apb
  task automatic chk(logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // clear sticky flags, launch, poll until idle with answer seen
  task automatic send(logic [31:0] q, o, p);
    apb(1'b1, reg_stat, 32'h6);
    apb(1'b1, reg_req, q);
    apb(1'b1, reg_dst_opt, o);
    apb(1'b1, reg_param, p);
    apb(1'b1, reg_ctrl, 32'h1);
    for (int n = 0; n < 60; n++) begin
      apb(1'b0, reg_stat, '0);
      if (rd[1:0] === 2'b10) break;
    end
  endtask : send
  task automatic summarize;
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, reg_dst_hi, '1);
    apb(1'b1, reg_dst_lo, '1);
    foreach (rows[i]) begin
      send(rows[i][0], rows[i][1], rows[i][2]);
      chk(rd & 32'hffffff07, {rows[i][0][28] ? type_rem_rsp : type_loc_rsp,
        rows[i][0][23:16], st_ok, 8'h02});
      if (rows[i][3] != 32'h0) begin
        apb(1'b0, reg_rdata, '0);
        chk({16'h0, rd[15:0]}, rows[i][3]);
      end
    end
    send(32'h08005450, 32'h0, 32'h0);
    chk(rd & 32'h2, 32'h0);
    apb(1'b0, 8'h40, '0);
    chk(rd, 32'h0);
    send(32'h08284e44, 32'h0, 32'h0);
    chk(rd & 32'h2, 32'h2);
    apb(1'b1, reg_stat, 32'h6);
    repeat (10) @(posedge pclk);
    apb(1'b0, reg_stat, '0);
    chk(rd & 32'hffff0002, {type_loc_rsp, 8'h28, 16'h2});
    chk(strobes, 32'h3);
    chk({13'h0, sidx, sval}, 32'h0004_0451);
    chk({30'h0, sec, nak}, 32'h3);
    chk(bads, 32'h0);
    presetn <= 1'b0;
    @(posedge pclk) presetn <= 1'b1;
    apb(1'b0, reg_stat, '0);
    chk(rd | {30'h0, sec, nak}, 32'h0);
    summarize();
  end
  // hang guard, about seventeen times the expected run
  initial begin
    #1000000;
    errors++;
    summarize();
  end
endmodule : at_command_frame_codec_tb
